// [design/pm_cmd_pkg.sv]
package pm_cmd_pkg;
	localparam logic [7:0] CODE_SELF_HEAT = 8'h00_B8;
	localparam logic [7:0] CODE_THERM_RATE = 8'h00_B9;
	localparam logic [7:0] CODE_THERM_RES = 8'h00_BA;
	localparam logic [7:0] CODE_IOUT_FINE = 8'h00_BB;
	localparam logic [7:0] CODE_NVM_UNLOCK = 8'h00_BD;
	localparam logic [7:0] CODE_NVM_ERASE = 8'h00_BE;
	localparam logic [7:0] CODE_NVM_DATA = 8'h00_BF;
	localparam logic [7:0] CODE_ENERGY = 8'h00_C0;
	localparam logic [7:0] CODE_ENERGY_CFG = 8'h00_C1;
	localparam logic [7:0] CODE_LOT = 8'h00_C2;
	localparam logic [7:0] CODE_TEMPCO = 8'h00_C3;
	localparam logic [7:0] CODE_IIN_MAX = 8'h00_C4;
	localparam logic [7:0] CODE_IIN_MIN = 8'h00_C5;
	localparam logic [7:0] CODE_PIN_MAX = 8'h00_C6;
	localparam logic [7:0] CODE_PIN_MIN = 8'h00_C7;
	localparam logic [7:0] CODE_XCMD = 8'h00_C8;
	localparam logic [7:0] CODE_XDATA0 = 8'h00_C9;
	localparam logic [7:0] CODE_XDATA1 = 8'h00_CA;
	localparam logic [7:0] CODE_CLR_ENERGY = 8'h00_CC;
	localparam logic [7:0] CODE_CHAN_CFG = 8'h00_D0;
	localparam logic [7:0] CODE_GLOBAL_CFG = 8'h00_D1;
	localparam logic [7:0] CODE_FAULT0_PROP = 8'h00_D2;
	localparam logic [15:0] RST_THERM_RATE = 16'h8000;
	localparam logic [15:0] RST_THERM_RES = 16'h8000;
	localparam logic [7:0] RST_ENERGY_CFG = 8'h00_00;
	localparam logic [15:0] RST_TEMPCO = 16'h0000;
	localparam logic [15:0] RST_CHAN_CFG = 16'h0080;
	localparam logic [15:0] RST_GLOBAL_CFG = 16'h0F7B;
	localparam logic [7:0] RST_FAULT0_PROP = 8'h00_00;
	localparam logic [7:0] NVM_UNLOCK_KEY = 8'h00_2B;
	localparam logic [7:0] ENERGY_BYTES = 8'h00_06;
	localparam int PROP_BIT = 0;
	localparam int CHANNELS = 4;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [15:0] wdata;
		logic [2:0] bidx;
	} cmd_req_t;

	typedef struct packed {
		logic valid;
		logic nack;
		logic [15:0] data;
	} cmd_rsp_t;

	typedef struct packed {
		logic valid;
		logic [1:0] ch;
		logic [15:0] heat;
		logic [15:0] iout;
	} chan_tel_t;

	typedef struct packed {
		logic valid;
		logic [15:0] iin;
		logic [15:0] pin;
		logic [15:0] energy_inc;
	} input_tel_t;

	typedef struct packed {
		logic erase;
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} nvm_req_t;
endpackage

// [design/power_manager_command_bank.sv]
`timescale 1ns/1ps
module power_manager_command_bank (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Command port from the serial front end.
	input wire logic [1:0] page,
	input wire pm_cmd_pkg::cmd_req_t req,
	output pm_cmd_pkg::cmd_rsp_t rsp,
	// Telemetry and memory side.
	input wire pm_cmd_pkg::chan_tel_t chan_tel,
	input wire pm_cmd_pkg::input_tel_t in_tel,
	input wire logic [3:0][7:0] lot_code,
	input wire logic [15:0] nvm_rdata,
	output pm_cmd_pkg::nvm_req_t nvm_req,
	// Additional host command strobe.
	output logic xhost_cmd_stb,
	// Configuration seen by the rest of the device.
	output logic [7:0] energy_config,
	output logic [15:0] input_sense_tempco,
	output logic [15:0] global_config,
	output logic [3:0][15:0] channel_config,
	output logic [3:0][15:0] sense_thermal_rate,
	output logic [3:0][15:0] sense_thermal_resistance,
	// Shared fault line 0, open drain.
	input wire logic [3:0] chan_faulted_off,
	output logic shared_fault_line0_out,
	output logic shared_fault_line0_oe
);
	typedef struct packed {
		pm_cmd_pkg::cmd_rsp_t rsp;
		pm_cmd_pkg::nvm_req_t nvm;
		logic xcmd_stb;
		logic unlocked;
		logic [3:0][15:0] heat;
		logic [3:0][15:0] iout;
		logic [3:0][15:0] rate;
		logic [3:0][15:0] res;
		logic [3:0][15:0] ccfg;
		logic [3:0][7:0] prop;
		logic [7:0] ecfg;
		logic [15:0] tempco;
		logic [15:0] gcfg;
		logic [15:0] xcmd;
		logic [15:0] xdata0;
		logic [15:0] xdata1;
		logic [23:0] energy;
		logic [23:0] elapsed;
		logic seen;
		logic [15:0] iin_max;
		logic [15:0] iin_min;
		logic [15:0] pin_max;
		logic [15:0] pin_min;
		logic fault_oe;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Maps a linear eleven-bit word onto one signed scale for comparing.
	function automatic logic signed [47:0] l11(input logic [15:0] w);
		logic signed [47:0] m;
		logic [4:0] sh;
		m = 48'(signed'(w[10:0]));
		sh = {~w[15], w[14:11]};
		l11 = m <<< sh;
	endfunction

	logic [47:0] energy_blk;
	logic [3:0] drive_fault;

	assign energy_blk = {s_q.elapsed, s_q.energy};

	genvar g;
	generate
		for (g = 0; g < pm_cmd_pkg::CHANNELS; g++) begin : g_prop
			// A faulted channel pulls the line only when enabled.
			assign drive_fault[g] = chan_faulted_off[g] &
				s_q.prop[g][pm_cmd_pkg::PROP_BIT];
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		s_d.rsp.valid = 1'b0;
		s_d.rsp.nack = 1'b0;
		s_d.nvm.erase = 1'b0;
		s_d.nvm.wr = 1'b0;
		s_d.nvm.rd = 1'b0;
		s_d.xcmd_stb = 1'b0;
		s_d.fault_oe = |drive_fault;

		// Telemetry updates land in the channel named by the sample.
		if (chan_tel.valid) begin
			s_d.heat[chan_tel.ch] = chan_tel.heat;
			s_d.iout[chan_tel.ch] = chan_tel.iout;
		end

		if (in_tel.valid) begin
			s_d.seen = 1'b1;
			s_d.energy = s_q.energy + 24'(in_tel.energy_inc);
			s_d.elapsed = s_q.elapsed + 24'd1;
			if (!s_q.seen || l11(in_tel.iin) > l11(s_q.iin_max)) begin
				s_d.iin_max = in_tel.iin;
			end
			if (!s_q.seen || l11(in_tel.iin) < l11(s_q.iin_min)) begin
				s_d.iin_min = in_tel.iin;
			end
			if (!s_q.seen || l11(in_tel.pin) > l11(s_q.pin_max)) begin
				s_d.pin_max = in_tel.pin;
			end
			if (!s_q.seen || l11(in_tel.pin) < l11(s_q.pin_min)) begin
				s_d.pin_min = in_tel.pin;
			end
		end

		// Each accepted command is answered on the next edge.
		if (req.valid) begin
			s_d.rsp.valid = 1'b1;
			s_d.rsp.data = 16'h0000;
			unique case (req.code)
			pm_cmd_pkg::CODE_SELF_HEAT: begin
				s_d.rsp.data = s_q.heat[page];
				s_d.rsp.nack = req.write;
			end
			pm_cmd_pkg::CODE_THERM_RATE: begin
				s_d.rsp.data = s_q.rate[page];
				if (req.write) begin
					s_d.rate[page] = req.wdata;
				end
			end
			pm_cmd_pkg::CODE_THERM_RES: begin
				s_d.rsp.data = s_q.res[page];
				if (req.write) begin
					s_d.res[page] = req.wdata;
				end
			end
			pm_cmd_pkg::CODE_IOUT_FINE: begin
				s_d.rsp.data = s_q.iout[page];
				s_d.rsp.nack = req.write;
			end
			pm_cmd_pkg::CODE_NVM_UNLOCK: begin
				s_d.rsp.data = {15'h0000, s_q.unlocked};
				if (req.write) begin
					s_d.unlocked = req.wdata[7:0] ==
						pm_cmd_pkg::NVM_UNLOCK_KEY;
					s_d.nvm.addr = 16'h0000;
				end
			end
			pm_cmd_pkg::CODE_NVM_ERASE: begin
				if (req.write && s_q.unlocked) begin
					s_d.nvm.erase = 1'b1;
					s_d.nvm.addr = 16'h0000;
				end
				s_d.rsp.nack = !s_q.unlocked;
			end
			pm_cmd_pkg::CODE_NVM_DATA: begin
				if (s_q.unlocked) begin
					// Each access steps the array address by one word.
					s_d.nvm.wr = req.write;
					s_d.nvm.rd = !req.write;
					s_d.nvm.wdata = req.wdata;
					s_d.nvm.addr = s_q.nvm.addr + 16'h0001;
					s_d.rsp.data = req.write ? 16'h0000 : nvm_rdata;
				end
				s_d.rsp.nack = !s_q.unlocked;
			end
			pm_cmd_pkg::CODE_ENERGY: begin
				// Byte 0 is the count, then energy and time low first.
				if (req.bidx == 3'd0) begin
					s_d.rsp.data = {8'h00, pm_cmd_pkg::ENERGY_BYTES};
				end else if (req.bidx <= 3'd6) begin
					s_d.rsp.data = {8'h00,
						energy_blk[8*(req.bidx-3'd1) +: 8]};
				end
				s_d.rsp.nack = req.write || req.bidx > 3'd6;
			end
			pm_cmd_pkg::CODE_ENERGY_CFG: begin
				s_d.rsp.data = {8'h00, s_q.ecfg};
				if (req.write) begin
					s_d.ecfg = req.wdata[7:0];
				end
			end
			pm_cmd_pkg::CODE_LOT: begin
				s_d.rsp.data = {8'h00, lot_code[page]};
				s_d.rsp.nack = req.write;
			end
			pm_cmd_pkg::CODE_TEMPCO: begin
				s_d.rsp.data = s_q.tempco;
				if (req.write) begin
					s_d.tempco = req.wdata;
				end
			end
			pm_cmd_pkg::CODE_IIN_MAX: begin
				s_d.rsp.data = s_q.iin_max;
				s_d.rsp.nack = req.write;
			end
			pm_cmd_pkg::CODE_IIN_MIN: begin
				s_d.rsp.data = s_q.iin_min;
				s_d.rsp.nack = req.write;
			end
			pm_cmd_pkg::CODE_PIN_MAX: begin
				s_d.rsp.data = s_q.pin_max;
				s_d.rsp.nack = req.write;
			end
			pm_cmd_pkg::CODE_PIN_MIN: begin
				s_d.rsp.data = s_q.pin_min;
				s_d.rsp.nack = req.write;
			end
			pm_cmd_pkg::CODE_XCMD: begin
				s_d.rsp.data = s_q.xcmd;
				if (req.write) begin
					s_d.xcmd = req.wdata;
					s_d.xcmd_stb = 1'b1;
				end
			end
			pm_cmd_pkg::CODE_XDATA0: begin
				s_d.rsp.data = s_q.xdata0;
				if (req.write) begin
					s_d.xdata0 = req.wdata;
				end
			end
			pm_cmd_pkg::CODE_XDATA1: begin
				s_d.rsp.data = s_q.xdata1;
				if (req.write) begin
					s_d.xdata1 = req.wdata;
				end
			end
			pm_cmd_pkg::CODE_CLR_ENERGY: begin
				if (req.write) begin
					s_d.energy = 24'h00_0000;
					s_d.elapsed = 24'h00_0000;
				end
				s_d.rsp.nack = !req.write;
			end
			pm_cmd_pkg::CODE_CHAN_CFG: begin
				s_d.rsp.data = s_q.ccfg[page];
				if (req.write) begin
					s_d.ccfg[page] = req.wdata;
				end
			end
			pm_cmd_pkg::CODE_GLOBAL_CFG: begin
				s_d.rsp.data = s_q.gcfg;
				if (req.write) begin
					s_d.gcfg = req.wdata;
				end
			end
			pm_cmd_pkg::CODE_FAULT0_PROP: begin
				s_d.rsp.data = {8'h00, s_q.prop[page]};
				if (req.write) begin
					s_d.prop[page] = req.wdata[7:0];
				end
			end
			default: begin
				s_d.rsp.nack = 1'b1;
			end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_q <= '0;
			s_q.rate <= {4{pm_cmd_pkg::RST_THERM_RATE}};
			s_q.res <= {4{pm_cmd_pkg::RST_THERM_RES}};
			s_q.ccfg <= {4{pm_cmd_pkg::RST_CHAN_CFG}};
			s_q.prop <= {4{pm_cmd_pkg::RST_FAULT0_PROP}};
			s_q.ecfg <= pm_cmd_pkg::RST_ENERGY_CFG;
			s_q.tempco <= pm_cmd_pkg::RST_TEMPCO;
			s_q.gcfg <= pm_cmd_pkg::RST_GLOBAL_CFG;
		end else begin
			s_q <= s_d;
		end
	end

	assign rsp = s_q.rsp;
	assign nvm_req = s_q.nvm;
	assign xhost_cmd_stb = s_q.xcmd_stb;
	assign energy_config = s_q.ecfg;
	assign input_sense_tempco = s_q.tempco;
	assign global_config = s_q.gcfg;
	assign channel_config = s_q.ccfg;
	assign sense_thermal_rate = s_q.rate;
	assign sense_thermal_resistance = s_q.res;
	assign shared_fault_line0_out = 1'b0;
	assign shared_fault_line0_oe = s_q.fault_oe;
endmodule // power_manager_command_bank

// [verification/bank_chk.sv]
`timescale 1ns/1ps
module bank_chk (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Command port.
	input wire pm_cmd_pkg::cmd_req_t req,
	input wire pm_cmd_pkg::cmd_rsp_t rsp,
	// Outputs watched, and the channel fault inputs.
	input wire pm_cmd_pkg::nvm_req_t nvm_req,
	input wire logic xhost_cmd_stb,
	input wire logic [7:0] energy_config,
	input wire logic [15:0] global_config,
	input wire logic [3:0] chan_faulted_off,
	input wire logic shared_fault_line0_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	wire wr = req.valid && req.write;
	property p_ans; req.valid |=> rsp.valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_ro; wr && req.code == 8'hC6 |=> rsp.nack; endproperty
	a_ro: assert property (p_ro) else $error("ro write taken");
	property p_gc;
		wr && req.code == 8'hD1 |=> global_config == $past(req.wdata);
	endproperty
	a_gc: assert property (p_gc) else $error("gcfg write");
	property p_ec;
		wr && req.code == 8'hC1 |=> energy_config == $past(req.wdata[7:0]);
	endproperty
	a_ec: assert property (p_ec) else $error("ecfg write");
	property p_er; nvm_req.erase |-> $past(wr && req.code == 8'hBE); endproperty
	a_er: assert property (p_er) else $error("stray erase");
	property p_dw; nvm_req.wr |-> $past(wr && req.code == 8'hBF); endproperty
	a_dw: assert property (p_dw) else $error("stray nvm write");
	property p_xs; wr && req.code == 8'hC8 |=> xhost_cmd_stb; endproperty
	a_xs: assert property (p_xs) else $error("no xhost strobe");
	property p_fl;
		chan_faulted_off == 4'h0 [*2] |-> !shared_fault_line0_oe;
	endproperty
	a_fl: assert property (p_fl) else $error("fault line held");
endmodule // bank_chk

bind power_manager_command_bank bank_chk u_chk (.mclk, .reset, .req, .rsp,
	.nvm_req, .xhost_cmd_stb, .energy_config, .global_config,
	.chan_faulted_off, .shared_fault_line0_oe);

// [verification/host_model.sv]
`timescale 1ns/1ps
module host_model (
	// Clock.
	input wire logic mclk,
	// Command port.
	output pm_cmd_pkg::cmd_req_t req,
	input wire pm_cmd_pkg::cmd_rsp_t rsp
);
	initial req = '0;
	// Idle request lines show junk so a stale value cannot pass.
	task automatic xfer(input logic wr, input logic [7:0] code,
		input logic [15:0] wd, input logic [2:0] bi,
		output logic nack, output logic [15:0] rd);
		@(negedge mclk);
		req = '{1'b1, wr, code, wd, bi};
		@(posedge mclk);
		@(negedge mclk);
		nack = rsp.valid === 1'b1 ? rsp.nack : 1'bx;
		rd = rsp.data;
		req = '{1'b0, ~wr, ~code, ~wd, ~bi};
	endtask
endmodule // host_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
	logic mclk = 0;
	logic reset = 1;
	logic [1:0] page = 0;
	pm_cmd_pkg::cmd_req_t req;
	pm_cmd_pkg::cmd_rsp_t rsp;
	pm_cmd_pkg::chan_tel_t ct = '0;
	pm_cmd_pkg::input_tel_t it = '0;
	pm_cmd_pkg::nvm_req_t nv;
	logic [3:0][7:0] lot = 32'h9C5A_3E71;
	logic [15:0] nrd = 16'hA55A;
	logic [15:0] gc, rd, x;
	logic [7:0] ec;
	logic [3:0] flt = 4'h0;
	logic xs, oe, nk, fo;
	logic [15:0] tc;
	logic [3:0][15:0] cc, tr, ts;
	logic [7:0] cd[7] = '{8'hB9, 8'hBA, 8'hD0, 8'hD2, 8'hC1, 8'hC3, 8'hD1};
	logic [15:0] rv[7] = '{16'h8000, 16'h8000, 16'h0080, 16'h0000,
		16'h0000, 16'h0000, 16'h0F7B};
	logic [15:0] m[int];
	int num_errors = 0;
	int tests_run = 0;
	int seed = 32'hc4fa;
	int e, hi[2], lo[2];
	always #10 mclk = ~mclk;
	host_model host (.mclk(mclk), .req(req), .rsp(rsp));
	power_manager_command_bank dut (.mclk(mclk), .reset(reset), .page(page),
		.req(req), .rsp(rsp), .chan_tel(ct), .in_tel(it), .lot_code(lot),
		.nvm_rdata(nrd), .nvm_req(nv), .xhost_cmd_stb(xs),
		.energy_config(ec), .input_sense_tempco(tc), .global_config(gc),
		.channel_config(cc), .sense_thermal_rate(tr),
		.sense_thermal_resistance(ts), .chan_faulted_off(flt),
		.shared_fault_line0_out(fo), .shared_fault_line0_oe(oe));
	task automatic check(input string s, input logic [16:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic op(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic [2:0] b, input logic [16:0] exp);
		host.xfer(w, c, d, b, nk, rd);
		check("cmd", {nk, w ? 16'h0000 : rd}, exp);
	endtask
	task automatic rw(input int i, input logic w);
		int k;
		logic [15:0] d;
		k = (i < 4 ? int'(page) : 0) * 256 + cd[i];
		d = 16'($random(seed));
		if (cd[i] inside {8'hC1, 8'hD2})
			d[15:8] = 8'h00;
		op(w, cd[i], d, 3'd0, {1'b0, w ? 16'h0000 : m[k]});
		if (w)
			m[k] = d;
	endtask
	task automatic all_rd();
		for (int p = 0; p < 4; p++) begin
			page = 2'(p);
			for (int i = 0; i < 7; i++)
				rw(i, 1'b0);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		reset = 0;
		for (int p = 0; p < 4; p++)
			for (int i = 0; i < 7; i++)
				m[(i < 4 ? p : 0) * 256 + cd[i]] = rv[i];
		all_rd();
		$display("defaults done");
		repeat (40) begin
			page = 2'($random(seed));
			rw($unsigned($random(seed)) % 7, 1'b1);
		end
		page = 2'd1;
		op(1'b1, 8'hD2, 16'h0001, 3'd0, 17'h0_0000);
		m[256 + 8'hD2] = 16'h0001;
		all_rd();
		check("gcfg", {1'b0, gc}, {1'b0, m[8'hD1]});
		check("ecfg", {9'h000, ec}, {1'b0, m[8'hC1]});
		check("tempco", {1'b0, tc}, {1'b0, m[8'hC3]});
		for (int p = 0; p < 4; p++) begin
			check("ccfg", {1'b0, cc[p]}, {1'b0, m[p * 256 + 8'hD0]});
			check("rate", {1'b0, tr[p]}, {1'b0, m[p * 256 + 8'hB9]});
			check("res", {1'b0, ts[p]}, {1'b0, m[p * 256 + 8'hBA]});
		end
		op(1'b1, 8'hC6, 16'h1234, 3'd0, 17'h1_0000);
		op(1'b0, 8'hBC, 16'h0000, 3'd0, 17'h1_0000);
		$display("registers done");
		e = 0;
		for (int s = 0; s < 8; s++) begin
			it = {1'b1, 6'h00, 10'($random(seed)), 6'h00, 10'($random(seed)),
				8'h00, 8'($random(seed))};
			e += it.energy_inc;
			for (int q = 0; q < 2; q++) begin
				x = q ? it.pin : it.iin;
				hi[q] = (s == 0 || x > hi[q]) ? x : hi[q];
				lo[q] = (s == 0 || x < lo[q]) ? x : lo[q];
			end
			@(negedge mclk);
		end
		it.valid = 1'b0;
		for (int q = 0; q < 4; q++)
			op(1'b0, 8'hC4 + 8'(q), 16'h0000, 3'd0,
				{1'b0, 16'(q[0] ? lo[q / 2] : hi[q / 2])});
		for (int b = 0; b < 7; b++)
			op(1'b0, 8'hC0, 16'h0000, 3'(b), {9'h000, 8'(b == 0 ? 6 :
				(b < 4 ? e : 8) >> 8 * ((b - 1) % 3))});
		op(1'b0, 8'hCC, 16'h0000, 3'd0, 17'h1_0000);
		op(1'b1, 8'hCC, 16'h0000, 3'd0, 17'h0_0000);
		for (int b = 1; b < 7; b++)
			op(1'b0, 8'hC0, 16'h0000, 3'(b), 17'h0_0000);
		for (int c = 0; c < 4; c++) begin
			ct = {1'b1, 2'(c), 16'(c * 16'h0111), 16'(c + 16'h0050)};
			@(negedge mclk);
		end
		ct.valid = 1'b0;
		for (int c = 0; c < 4; c++) begin
			page = 2'(c);
			op(1'b0, 8'hB8, 16'h0000, 3'd0, {1'b0, 16'(c * 16'h0111)});
			op(1'b0, 8'hBB, 16'h0000, 3'd0, {1'b0, 16'(c + 16'h0050)});
			op(1'b0, 8'hC2, 16'h0000, 3'd0, {9'h000, lot[c]});
		end
		$display("telemetry done");
		op(1'b1, 8'hBF, 16'h1111, 3'd0, 17'h1_0000);
		op(1'b1, 8'hBD, 16'h002B, 3'd0, 17'h0_0000);
		op(1'b1, 8'hBE, 16'h0000, 3'd0, 17'h0_0000);
		check("erase", {nv.erase, nv.addr}, 17'h1_0000);
		x = 16'($random(seed));
		op(1'b1, 8'hBF, x, 3'd0, 17'h0_0000);
		check("nvm wr", {nv.wr, nv.wdata}, {1'b1, x});
		nrd = 16'($random(seed));
		op(1'b0, 8'hBF, 16'h0000, 3'd0, {1'b0, nrd});
		check("nvm rd", {nv.rd, nv.addr}, 17'h1_0002);
		x = 16'($random(seed));
		op(1'b1, 8'hC8, x, 3'd0, 17'h0_0000);
		check("xcmd", {xs, 16'h0000}, 17'h1_0000);
		op(1'b0, 8'hC8, 16'h0000, 3'd0, {1'b0, x});
		op(1'b1, 8'hC9, x, 3'd0, 17'h0_0000);
		op(1'b1, 8'hCA, ~x, 3'd0, 17'h0_0000);
		op(1'b0, 8'hC9, 16'h0000, 3'd0, {1'b0, x});
		op(1'b0, 8'hCA, 16'h0000, 3'd0, {1'b0, ~x});
		$display("ports done");
		for (int f = 0; f < 16; f++) begin
			flt = 4'(f);
			x = 16'h0000;
			for (int p = 0; p < 4; p++)
				x[0] = x[0] | (flt[p] & m[p * 256 + 8'hD2][0]);
			repeat (2) @(negedge mclk);
			check("fault oe", {16'h0000, oe}, {16'h0000, x[0]});
			check("fault out", {16'h0000, fo}, 17'h0_0000);
		end
		$display("fault done");
		end_of_test();
	end
endmodule // tb
